// ==== include/phy_pins_defs.vh ====
`ifndef PHY_PINS_DEFS_VH
`define PHY_PINS_DEFS_VH

// Register offsets (byte addresses)
`define OFS_CTRL        8'h00
`define OFS_LED_CFG     8'h04
`define OFS_STRAP       8'h08
`define OFS_STATUS      8'h0C
`define OFS_IRQ_CFG     8'h10
`define OFS_RX_FRAME    8'h14

// Control register 0h field positions
`define CTRL_DUPLEX_BIT   8
`define CTRL_ISOLATE_BIT  10
`define CTRL_ANEG_BIT     12
`define CTRL_SPEED_BIT    13

// LED mode field (register 1Fh bits 5:4)
`define LED_MODE_LSB     4
`define LED_MODE_LINKACT 2'h0
`define LED_MODE_LINK    2'h1

// Upper address bits, never strapped
`define ADDR_UPPER_RST   2'h0

// Activity blink half period in ns and derived cycles at 20 MHz
`define BLINK_HALF_NS    100000
`define CLK_PERIOD_NS    50
`define BLINK_CYCLES     (`BLINK_HALF_NS / `CLK_PERIOD_NS)

// Config code reset value (MII default)
`define CFG_RST          3'h0

`endif

// ==== core/pin_sync.v ====
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of pin inputs
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ==== core/phy_strap_led_mii_pins.v ====
// Summary of operation
// (R1) Each strap level is captured once at reset release and then held.
// (R2) Dual-use pins are inputs during reset, drive outputs after release.
// (R3) Receive data bits 3,2,1 become address bits 0,1,2.
// (R4) Receive data bit 0 gives the initial duplex choice.
// (R5) Collision, carrier sense, data valid form config code bits 0,1,2.
// (R6) Receive clock pin level becomes the broadcast-disable setting.
// (R7) Receive error pin level becomes the initial isolate setting.
// (R8) Interrupt pin level selects board connectivity test mode.
// (R9) First LED pin captured into control bit 12, auto-negotiation enable.
// (R10) Second LED pin captured into control bit 13, speed select.
// (R11) Link LED: mode 00 link/activity toggle, mode 01 link only.
// (R12) Speed LED: mode 00 shows speed, mode 01 activity toggle.
// (R13) LED modes 10 and 11 are reserved, software avoids them.
// (R14) Receive nibble valid to the MAC only while data valid is high.
// (R15) MAC transmit nibble is valid only while transmit enable is high.
// (R16) Management clock comes from the station; data line open-drain only.
// (R17) Interrupt output is open-drain, programmable sources, low when active.
// (R18) Address bits 4 and 3 are zero, not strapped.
// (R19) Captured isolate strap loads control bit 10.
// (R20) Captured duplex loads control bit 8, high half, low full.
// (R21) Low test strap enables connectivity test; high leaves it off.
// (R22) During reset dual-use pins undriven, LED and strap logic initial. The strap registers keep their last captured values through chip reset.
// (R23) Isolate active keeps interface outputs undriven.
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "phy_pins_defs.vh"
module phy_strap_led_mii_pins #(
  parameter BLINK_CYCLES = `BLINK_CYCLES
) (
  input  wire        mclk,
  input  wire        rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Chip reset pin, active low
  input  wire        chip_rst_n,
  // Receive side from core
  input  wire [3:0]  core_rxd,
  input  wire        core_rxdv,
  input  wire        core_rxer,
  input  wire        core_col,
  input  wire        core_crs,
  input  wire        core_rxc,
  input  wire        link_up,
  input  wire        speed_100,
  input  wire        activity,
  // Dual-use receive pins
  input  wire [3:0]  rxd_in,
  output reg  [3:0]  rxd_out,
  output wire [3:0]  rxd_oe,
  input  wire        rxdv_in,
  output reg         rxdv_out,
  output wire        rxdv_oe,
  input  wire        rxc_in,
  output reg         rxc_out,
  output wire        rxc_oe,
  input  wire        rxer_in,
  output reg         rxer_out,
  output wire        rxer_oe,
  input  wire        col_in,
  output reg         col_out,
  output wire        col_oe,
  input  wire        crs_in,
  output reg         crs_out,
  output wire        crs_oe,
  // LED pins
  input  wire        link_led_in,
  output reg         link_led_out,
  output wire        link_led_oe,
  input  wire        speed_led_in,
  output reg         speed_led_out,
  output wire        speed_led_oe,
  // Interrupt pin, open-drain
  input  wire        irq_in,
  output wire        irq_out_n,
  output wire        irq_oe,
  input  wire        irq_event,
  // Transmit pins from MAC
  input  wire        txc_in,
  input  wire        txen_in,
  input  wire [3:0]  txd_in,
  output reg  [3:0]  tx_nibble,
  output reg         tx_nibble_valid,
  // Management pins
  input  wire        mdc_in,
  input  wire        mdio_in,
  input  wire        mgmt_drive_low,
  output wire        mdio_out,
  output wire        mdio_oe,
  output wire        mdc_rise,
  output wire        mdio_sync,
  // Captured strap results
  output wire [4:0]  mgmt_station_addr,
  output wire [2:0]  iface_cfg,
  output wire        broadcast_disable_strap,
  output wire        autoneg_enable_strap,
  output wire        test_mode_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  wire [20:0] pin_raw;
  wire [20:0] pin_s;
  assign pin_raw = {rxd_in[3:1], mdio_in, mdc_in, txd_in, txen_in, txc_in, chip_rst_n,
                    speed_led_in, link_led_in, irq_in, crs_in, col_in,
                    rxer_in, rxc_in, rxdv_in, rxd_in[0]};

  pin_sync #(.WIDTH(21)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  (pin_raw),
    .dout (pin_s)
  );

  wire s_rxd0   = pin_s[0];
  wire s_rxdv   = pin_s[1];
  wire s_rxc    = pin_s[2];
  wire s_rxer   = pin_s[3];
  wire s_col    = pin_s[4];
  wire s_crs    = pin_s[5];
  wire s_irq    = pin_s[6];
  wire s_link_led_out   = pin_s[7];
  wire s_speed_led_out   = pin_s[8];
  wire s_rst_n  = pin_s[9];
  wire s_txc    = pin_s[10];
  wire s_txen   = pin_s[11];
  wire [3:0] s_txd = pin_s[15:12];
  wire s_mdc    = pin_s[16];
  wire s_mdio   = pin_s[17];
  wire [2:0] rxd_hi_s = pin_s[20:18];

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture at chip reset release
  reg        run;
  reg        straps_taken;
  reg [2:0]  addr_low;
  reg        duplex_strap;
  reg [2:0]  cfg_strap;
  reg        bcast_strap;
  reg        iso_strap;
  reg        nand_strap;
  reg        aneg_strap;
  reg        speed_strap;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      run          <= 1'b0;
      straps_taken <= 1'b0;
      addr_low     <= 3'h0;
      duplex_strap <= 1'b1;
      cfg_strap    <= `CFG_RST;
      bcast_strap  <= 1'b0;
      iso_strap    <= 1'b0;
      nand_strap   <= 1'b1;
      aneg_strap   <= 1'b1;
      speed_strap  <= 1'b1;
    end else if (!s_rst_n) begin
      run          <= 1'b0; // [R22]
      straps_taken <= 1'b0;
    end else begin
      run <= 1'b1; // [R2]
      if (!straps_taken) begin
        straps_taken <= 1'b1; // [R1]
        addr_low     <= {rxd_hi_s[0], rxd_hi_s[1], rxd_hi_s[2]}; // [R3]
        duplex_strap <= s_rxd0; // [R4]
        cfg_strap    <= {s_rxdv, s_crs, s_col}; // [R5]
        bcast_strap  <= s_rxc; // [R6]
        iso_strap    <= s_rxer; // [R7]
        nand_strap   <= s_irq; // [R8]
        aneg_strap   <= s_link_led_out; // [R9]
        speed_strap  <= s_speed_led_out; // [R10]
      end
    end
  end

  assign mgmt_station_addr       = {`ADDR_UPPER_RST, addr_low}; // [R18]
  assign iface_cfg               = cfg_strap;
  assign broadcast_disable_strap = bcast_strap;
  assign autoneg_enable_strap    = aneg_strap;
  assign test_mode_en            = ~nand_strap; // [R21]

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [15:0] ctrl;
  reg  [1:0]  led_mode;
  reg         irq_en;
  reg         irq_flag;
  reg         load_pend;
  reg  [15:0] rx_frames;
  reg         ph_write;
  reg  [7:0]  ph_addr;
  reg  [31:0] rdata;

  wire        isolate = ctrl[`CTRL_ISOLATE_BIT];
  wire        bus_go  = hsel & hready & htrans[1];
  wire        wr_ctrl = ph_write & (ph_addr == `OFS_CTRL);
  wire        wr_irq  = ph_write & (ph_addr == `OFS_IRQ_CFG);
  wire        irq_set = irq_en & irq_event;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end else begin
      ph_write <= bus_go & hwrite;
      ph_addr  <= bus_go ? haddr : ph_addr;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl      <= 16'h0000;
      led_mode  <= `LED_MODE_LINKACT;
      irq_en    <= 1'b0;
      irq_flag  <= 1'b0;
      load_pend <= 1'b1;
    end else begin
      if (!s_rst_n) begin
        load_pend <= 1'b1;
      end else if (load_pend && straps_taken) begin
        load_pend                   <= 1'b0;
        ctrl[`CTRL_DUPLEX_BIT]      <= duplex_strap; // [R20]
        ctrl[`CTRL_ISOLATE_BIT]     <= iso_strap; // [R19]
        ctrl[`CTRL_ANEG_BIT]        <= aneg_strap; // [R9]
        ctrl[`CTRL_SPEED_BIT]       <= speed_strap; // [R10]
      end else if (wr_ctrl) begin
        ctrl <= hwdata[15:0];
      end
      if (ph_write && ph_addr == `OFS_LED_CFG)
        led_mode <= hwdata[`LED_MODE_LSB+1:`LED_MODE_LSB]; // [R13]
      if (wr_irq)
        irq_en <= hwdata[0];
      if (irq_set)
        irq_flag <= 1'b1; // [R17]
      else if (wr_irq && hwdata[1])
        irq_flag <= 1'b0;
    end
  end

  always @* begin
    case (ph_addr)
      `OFS_CTRL:     rdata = {16'h0000, ctrl};
      `OFS_LED_CFG:  rdata = {26'h0, led_mode, 4'h0};
      `OFS_STRAP:    rdata = {13'h0, ~nand_strap, aneg_strap, speed_strap, iso_strap, bcast_strap,
                              duplex_strap, cfg_strap, 7'h00, addr_low};
      `OFS_STATUS:   rdata = {29'h0, run, load_pend, straps_taken};
      `OFS_IRQ_CFG:  rdata = {30'h0, irq_flag, irq_en};
      `OFS_RX_FRAME: rdata = {16'h0000, rx_frames};
      default:       rdata = 32'h0000_0000;
    endcase
  end

  assign hrdata    = rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Output enables
  wire drive_mii = run & ~isolate;
  assign rxd_oe   = {4{drive_mii}}; // [R23]
  assign rxdv_oe  = drive_mii; // [R23]
  assign rxc_oe   = drive_mii;
  assign rxer_oe  = drive_mii;
  assign col_oe   = drive_mii;
  assign crs_oe   = drive_mii;
  assign link_led_oe  = run; // [R2]
  assign speed_led_oe = run; // [R22]

  ////////////////////////////////////////////////////////////////////////////
  // MII receive outputs
  reg rxdv_d;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxd_out   <= 4'h0;
      rxdv_out  <= 1'b0;
      rxc_out   <= 1'b0;
      rxer_out  <= 1'b0;
      col_out   <= 1'b0;
      crs_out   <= 1'b0;
      rxdv_d    <= 1'b0;
      rx_frames <= 16'h0000;
    end else begin
      rxd_out  <= core_rxdv ? core_rxd : 4'h0; // [R14]
      rxdv_out <= core_rxdv; // [R14]
      rxc_out  <= core_rxc;
      rxer_out <= core_rxer;
      col_out  <= core_col;
      crs_out  <= core_crs;
      rxdv_d   <= core_rxdv;
      if (core_rxdv && !rxdv_d)
        rx_frames <= rx_frames + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // MII transmit sampling on transmit clock rise
  reg txc_d;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      txc_d           <= 1'b0;
      tx_nibble       <= 4'h0;
      tx_nibble_valid <= 1'b0;
    end else begin
      txc_d           <= s_txc;
      tx_nibble_valid <= 1'b0;
      if (s_txc && !txc_d && s_txen) begin
        tx_nibble       <= s_txd; // [R15]
        tx_nibble_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management clock edge and open-drain data
  reg mdc_d;
  always @(posedge mclk or posedge rst) begin
    if (rst)
      mdc_d <= 1'b0;
    else
      mdc_d <= s_mdc;
  end
  assign mdc_rise  = s_mdc & ~mdc_d; // [R16]
  assign mdio_sync = s_mdio;
  assign mdio_out  = 1'b0;
  assign mdio_oe   = run & mgmt_drive_low; // [R16]

  // Interrupt open-drain: pulled low only when flagged
  assign irq_out_n = 1'b0;
  assign irq_oe    = run & irq_flag; // [R17]

  ////////////////////////////////////////////////////////////////////////////
  // LEDs
  reg [31:0] blink_cnt;
  reg        blink;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      blink_cnt <= 32'h0000_0000;
      blink     <= 1'b0;
    end else if (blink_cnt >= BLINK_CYCLES - 1) begin
      blink_cnt <= 32'h0000_0000;
      blink     <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_led_out  <= 1'b1;
      speed_led_out <= 1'b1;
    end else if (!run) begin
      link_led_out  <= 1'b1; // [R22]
      speed_led_out <= 1'b1;
    end else begin
      case (led_mode)
        `LED_MODE_LINKACT: begin
          link_led_out  <= ~link_up ? 1'b1 : (activity ? blink : 1'b0); // [R11]
          speed_led_out <= ~speed_100; // [R12]
        end
        `LED_MODE_LINK: begin
          link_led_out  <= ~link_up; // [R11]
          speed_led_out <= activity ? blink : 1'b1; // [R12]
        end
        default: begin
          link_led_out  <= 1'b1; // [R13]
          speed_led_out <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ==== bench/pins_checker.sv ====
`timescale 1ns/1ps
module pins_checker (
  input logic       mclk,
  input logic       rst,
  input logic       chip_rst_n,
  input logic [3:0] core_rxd,
  input logic       core_rxdv,
  input logic       core_rxer,
  input logic       core_col,
  input logic       core_crs,
  input logic       core_rxc,
  input logic       rxer_out,
  input logic       col_out,
  input logic       crs_out,
  input logic       rxc_out,
  input logic [3:0] rxd_out,
  input logic [3:0] rxd_oe,
  input logic       rxdv_out,
  input logic       link_led_oe,
  input logic       irq_out_n,
  input logic       irq_oe,
  input logic       mdio_out,
  input logic       mdio_oe,
  input logic       mgmt_drive_low,
  input logic       txc_in,
  input logic       txen_in,
  input logic       tx_nibble_valid,
  input logic [4:0] mgmt_station_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence chip_low;
    !chip_rst_n [*4];
  endsequence
  sequence tx_beat;
    !txc_in ##1 (txc_in && txen_in);
  endsequence
  a_oe_in_reset: assert property (chip_low |-> rxd_oe == 4'h0 && !link_led_oe && !irq_oe && !mdio_oe)
    else $error("pin driven in reset");
  a_strap_held: assert property (chip_rst_n [*6] |-> $stable(mgmt_station_addr))
    else $error("strap changed");
  a_addr_upper: assert property (mgmt_station_addr[4:3] == 2'h0)
    else $error("upper address set");
  a_rx_copy: assert property (##1 rxdv_out == $past(core_rxdv) &&
                              rxd_out == ($past(core_rxdv) ? $past(core_rxd) : 4'h0))
    else $error("receive nibble wrong");
  a_side_copy: assert property (##1 {rxer_out, col_out, crs_out, rxc_out} ==
                                $past({core_rxer, core_col, core_crs, core_rxc}))
    else $error("receive side pins wrong");
  a_mii_run: assert property (rxd_oe != 4'h0 |-> link_led_oe && rxd_oe == 4'hF)
    else $error("interface driven early");
  a_irq_drain: assert property (irq_oe |-> !irq_out_n && link_led_oe)
    else $error("interrupt not open drain");
  a_mdio_drain: assert property (mdio_oe == (link_led_oe && mgmt_drive_low) && !mdio_out)
    else $error("data line not open drain");
  a_tx_taken: assert property (tx_beat |-> ##[1:5] tx_nibble_valid)
    else $error("nibble not taken");
endmodule
bind phy_strap_led_mii_pins pins_checker pins_checker_inst (.*);

// ==== bench/mac_model.sv ====
`timescale 1ns/1ps
module mac_model (
  output logic       txc,
  output logic       txen,
  output logic [3:0] txd
);
  initial begin
    txc = 1'b0;
    txen = 1'b0;
    txd = 4'h0;
  end
  // One frame, then a beat with enable low; clock idle outside
  task automatic send(input logic [31:0] w, input int n);
    for (int i = 0; i <= n; i++) begin
      txen = i < n;
      txd = i < n ? w[4*i+:4] : ~txd;
      #200 txc = 1'b1;
      #200 txc = 1'b0;
    end
    txen = 1'b0;
    txd = ~txd;
  endtask
endmodule

// ==== bench/test_phy_strap_led_mii_pins.sv ====
`timescale 1ns/1ps
`include "phy_pins_defs.vh"
module test_phy_strap_led_mii_pins;
  logic        mclk, rst, hsel, hwrite, chip_rst_n, core_rxdv, link_up, speed_100, activity;
  logic        irq_event, mgmt_drive_low, core_rxer, core_col, core_crs, core_rxc, mdc_in;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [3:0]  core_rxd;
  logic [11:0] st;
  wire  [31:0] hrdata;
  wire  [3:0]  rxd_out, rxd_oe, tx_nibble, txd_in;
  wire  [4:0]  mgmt_station_addr;
  wire  [2:0]  iface_cfg;
  wire         hreadyout, hresp, rxdv_out, rxdv_oe, rxc_out, rxc_oe, rxer_out, rxer_oe, col_out, col_oe;
  wire         crs_out, crs_oe, link_led_out, link_led_oe, speed_led_out, speed_led_oe, irq_out_n, irq_oe;
  wire         txc_in, txen_in, tx_nibble_valid, mdio_out, mdio_oe, mdc_rise, mdio_sync;
  wire         broadcast_disable_strap, autoneg_enable_strap, test_mode_en;
  wire         hready = hreadyout;
  wire         mdio_in = !mdio_oe;
  wire  [11:0] oe_v = {irq_oe, speed_led_oe, link_led_oe, crs_oe, col_oe, rxer_oe, rxc_oe, rxdv_oe, rxd_oe};
  wire  [11:0] out_v = {irq_out_n, speed_led_out, link_led_out, crs_out, col_out, rxer_out, rxc_out,
                        rxdv_out, rxd_out};
  wire  [11:0] p = (oe_v & out_v) | (~oe_v & st);
  int          num_errors = 0;
  int          n_checks = 0;
  logic [3:0]  rxq[$];
  logic [3:0]  txq[$];

  phy_strap_led_mii_pins #(.BLINK_CYCLES(4)) phy_strap_led_mii_pins_inst (.*, .rxd_in(p[3:0]), .rxdv_in(p[4]),
    .rxc_in(p[5]), .rxer_in(p[6]), .col_in(p[7]), .crs_in(p[8]), .link_led_in(p[9]), .speed_led_in(p[10]),
    .irq_in(p[11]));
  mac_model mac_model_inst (.txc(txc_in), .txen(txen_in), .txd(txd_in));

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r & m);
  endtask

  task automatic strap(input logic [11:0] v);
    chip_rst_n <= 1'b0;
    st <= v;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("oe_rst", 0, {rxd_oe, rxdv_oe, link_led_oe, speed_led_oe, irq_oe});
    @(posedge mclk);
    chip_rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    st <= ~v;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("addr", {2'h0, v[1], v[2], v[3]}, mgmt_station_addr);
    chk("cfg", {v[4], v[8], v[7]}, iface_cfg);
    chk("bcast", v[5], broadcast_disable_strap);
    chk("aneg", v[9], autoneg_enable_strap);
    chk("test", !v[11], test_mode_en);
    chk("mii_oe", v[6] ? 4'h0 : 4'hF, rxd_oe);
    @(posedge mclk);
    rchk("ctrl", `OFS_CTRL, 32'h3500, {v[10], v[9], 1'b0, v[6], 1'b0, v[0], 8'h0});
    rchk("strap", `OFS_STRAP, 32'h3FC07,
         {v[9], v[10], v[6], v[5], v[0], v[4], v[8], v[7], 7'h0, v[1], v[2], v[3]});
    rchk("status", `OFS_STATUS, 32'h7, 32'h5);
  endtask

  ////////////////////////////////////////
  always @(negedge mclk) begin
    if (rxdv_out === 1'b1) chk("rxd", rxq.size() ? rxq.pop_front() : 4'hX, rxd_out);
    if (tx_nibble_valid === 1'b1) chk("txd", txq.size() ? txq.pop_front() : 4'hX, tx_nibble);
  end

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end

  initial begin
    logic [31:0] r, w;
    int          tl, ts;
    logic        pl, ps;
    {hsel, hwrite, core_rxdv, link_up, speed_100, activity, irq_event, mgmt_drive_low} = '0;
    {core_rxer, core_col, core_crs, core_rxc, mdc_in, haddr, htrans, hsize, hwdata, core_rxd} = '0;
    chip_rst_n = 1'b0;
    st = 12'hFFF;
    rst = 1'b1;
    void'($urandom(32'h8775));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 2; k++) strap(k ? 12'($urandom) & 12'hFBF : 12'($urandom) | 12'h040);
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, `OFS_LED_CFG, 32'(m) << 4, r);
      for (int c = 0; c < 4; c++) begin
        link_up <= c[0];
        speed_100 <= c[1];
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("link_led_out", m > 1 || !c[0], link_led_out);
        chk("speed_led_out", m > 0 || !c[1], speed_led_out);
        @(posedge mclk);
      end
      activity <= 1'b1;
      tl = 0;
      ts = 0;
      pl = link_led_out;
      ps = speed_led_out;
      repeat (24) begin
        @(negedge mclk);
        tl += int'(link_led_out !== pl);
        ts += int'(speed_led_out !== ps);
        pl = link_led_out;
        ps = speed_led_out;
      end
      chk("blink", m == 0 ? 2'h2 : m == 1 ? 2'h1 : 2'h0, {tl > 1, ts > 1});
      @(posedge mclk);
      activity <= 1'b0;
    end
    for (int i = 0; i < 12; i++) begin
      w[3:0] = 4'($urandom);
      core_rxd <= w[3:0];
      core_rxdv <= i % 3 != 0;
      {core_rxer, core_col, core_crs, core_rxc} <= 4'($urandom);
      if (i % 3 != 0) rxq.push_back(w[3:0]);
      @(posedge mclk);
    end
    core_rxdv <= 1'b0;
    w = $urandom;
    for (int i = 0; i < 6; i++) txq.push_back(w[4*i+:4]);
    #13;
    mac_model_inst.send(w, 6);
    @(posedge mclk);
    rchk("frames", `OFS_RX_FRAME, 32'hFFFF, 32'h4);
    st[11] <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, `OFS_IRQ_CFG, 32'(e), r);
      irq_event <= 1'b1;
      @(posedge mclk);
      irq_event <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("irq_pin", e == 0, p[11]);
      @(posedge mclk);
      rchk("irq_flag", `OFS_IRQ_CFG, 32'h3, 32'(e) * 32'h3);
      bus(1'b1, `OFS_IRQ_CFG, 32'h2, r);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("irq_clr", 0, irq_oe);
      @(posedge mclk);
    end
    for (int b = 0; b < 2; b++) begin
      mgmt_drive_low <= b[0];
      mdc_in <= b[0];
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("mdio", !b[0], mdio_in);
      chk("mdc_rise", b[0], mdc_rise);
      chk("mdio_sync", !b[0], mdio_sync);
      @(posedge mclk);
    end
    bus(1'b1, 8'h40, 32'hFFFFFFFF, r);
    rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    repeat (4) @(posedge mclk);
    chk("queues", 0, rxq.size() + txq.size());
    print_verdict();
  end
endmodule
